/* pkg/irq_vector_defs.vh */
// Purpose: shared constants of the peripheral interrupt vector unit
// Assumes: included by bare name from each rtl file
// Notes:   definitions only, no logic
`ifndef IRQ_VECTOR_DEFS_VH
`define IRQ_VECTOR_DEFS_VH
// register addresses
`define ADDR_CORE_IE    8'ha8
`define ADDR_VECTOR     16'hff92
// core enable register layout
`define IE_EXT0         0
`define IE_TIMER0       1
`define IE_EXT1         2
`define IE_TIMER1       3
`define IE_SERIAL       4
`define IE_GLOBAL       7
`define IE_WRITE_MASK   8'h9f
`define IE_RESET        8'h00
// core entry addresses
`define ENTRY_RESET     16'h0000
`define ENTRY_EXT0      16'h0003
`define ENTRY_TIMER0    16'h000b
`define ENTRY_EXT1      16'h0013
`define ENTRY_TIMER1    16'h001b
`define ENTRY_SERIAL    16'h0023
// vector register
`define VEC_NONE        8'h00
`define GROUP_BASE      4'h1
`define SLOT_COUNT      8
// flat source index = (group - 1) * 8 + slot
`define SRC_OUT_EP1     1
`define SRC_OUT_EP2     2
`define SRC_OUT_EP3     3
`define SRC_IN_EP1      9
`define SRC_IN_EP2      10
`define SRC_IN_EP3      11
`define SRC_SETUP_OVR   16
`define SRC_SETUP_RX    17
`define SRC_RESUME      20
`define SRC_SUSPEND     21
`define SRC_BUS_RESET   22
`define SRC_WAKEUP      23
`define SRC_SB_TXE      24
`define SRC_SB_RXF      25
`define SRC_IN_EP0      26
`define SRC_OUT_EP0     27
`define SRC_UART_STAT   32
`define SRC_UART_MODEM  33
`define SRC_UART_RXF    40
`define SRC_UART_TXE    41
`define SRC_DMA1        56
`define SRC_DMA3        58
`endif

/* rtl/source_order_arbiter.v */
// Purpose: pending flags and arrival order for the eight slots of one group
// Assumes: set_req and clr_req are synchronous to clock
// Notes:   oldest pending slot wins; equal arrival goes to the lower slot
`timescale 1ns/100ps
`default_nettype none
`include "irq_vector_defs.vh"
module source_order_arbiter (
	input  wire       clock,
	input  wire       reset_n,
	input  wire [7:0] set_req,
	input  wire [7:0] clr_req,
	output reg  [7:0] pending_q,
	output wire       any_pending,
	output reg  [2:0] winner
);
	wire [7:0]  arrive;   // slot becomes (or re-becomes) pending now
	wire [63:0] older;    // older[i*8+j]: slot j arrived before slot i
	reg         blocked;  // scan helper
	integer     k;        // scan index
	integer     m;        // scan index

	// a clear in the same cycle as a set counts as a fresh arrival
	assign arrive      = set_req & (~pending_q | clr_req);
	assign any_pending = |pending_q;

	// pending flags: set wins over clear
	always @(posedge clock) begin
		if (!reset_n) begin
			pending_q <= 8'h00;
		end else begin
			pending_q <= (pending_q & ~clr_req) | set_req;
		end
	end

	// age matrix, one flop per ordered pair
	genvar i, j;
	generate
		for (i = 0; i < `SLOT_COUNT; i = i + 1) begin : g_row
			for (j = 0; j < `SLOT_COUNT; j = j + 1) begin : g_col
				reg older_bit_q;  // slot j ahead of slot i
				always @(posedge clock) begin
					if (!reset_n) begin
						older_bit_q <= 1'b0;
					end else if (arrive[i]) begin
						// everyone still waiting is ahead of a newcomer
						older_bit_q <= (pending_q[j] & ~clr_req[j] & ~arrive[j]) |
							((j < i) ? arrive[j] : 1'b0);
					end else if (arrive[j]) begin
						// a re-arrival drops to the back of the line
						older_bit_q <= 1'b0;
					end
				end
				assign older[i*8+j] = older_bit_q;
			end
		end
	endgenerate

	// pick the pending slot that nobody pending is ahead of
	always @* begin
		winner  = 3'h0;
		blocked = 1'b0;
		for (k = `SLOT_COUNT - 1; k >= 0; k = k - 1) begin
			blocked = 1'b0;
			for (m = 0; m < `SLOT_COUNT; m = m + 1) begin
				if (older[k*8+m] && pending_q[m]) begin
					blocked = 1'b1;
				end
			end
			if (pending_q[k] && !blocked) begin
				winner = k[2:0];
			end
		end
	end
endmodule // source_order_arbiter
`default_nettype wire

/* rtl/core_irq_gate.v */
// Purpose: standard enable register and gating of the five core sources
// Assumes: core special-function writes arrive as a one-cycle strobe
// Notes:   entry address is registered, one cycle behind the sources
`timescale 1ns/100ps
`default_nettype none
`include "irq_vector_defs.vh"
module core_irq_gate (
	input  wire        clock,
	input  wire        reset_n,
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire [7:0]  sfr_wdata,
	input  wire        combined_n,
	input  wire        combined_peripheral_request_level_select,
	input  wire        timer0_irq,
	input  wire        ext1_irq,
	input  wire        timer1_irq,
	input  wire        serial_irq,
	output reg  [7:0]  ie_q,
	output reg         core_irq_valid,
	output reg  [15:0] core_irq_entry
);
	reg        level_mode_q;     // 0 edge, 1 active-low level
	reg        combined_prev_q;  // last combined line, for falling edge
	wire       ext0_req;         // external 0 request toward the core
	wire [4:0] live;             // sources passed by their enables

	// enable register at the core's special-function address
	always @(posedge clock) begin
		if (!reset_n) begin
			ie_q <= `IE_RESET;
		end else if (sfr_wr && sfr_addr == `ADDR_CORE_IE) begin
			ie_q <= sfr_wdata & `IE_WRITE_MASK;
		end
	end

	// trigger mode: edge after reset until firmware selects level
	always @(posedge clock) begin
		if (!reset_n) begin
			level_mode_q    <= 1'b0;
			combined_prev_q <= 1'b1;
		end else begin
			level_mode_q    <= combined_peripheral_request_level_select;
			combined_prev_q <= combined_n;
		end
	end

	// edge mode would miss requests that overlap; firmware picks level
	assign ext0_req = level_mode_q ? ~combined_n :
		(combined_prev_q & ~combined_n);

	// global gate over the per-source enables
	assign live = {serial_irq & ie_q[`IE_SERIAL], timer1_irq & ie_q[`IE_TIMER1],
		ext1_irq & ie_q[`IE_EXT1], timer0_irq & ie_q[`IE_TIMER0],
		ext0_req & ie_q[`IE_EXT0]} & {5{ie_q[`IE_GLOBAL]}};

	// fixed order: external 0 first, serial port last
	always @(posedge clock) begin
		if (!reset_n) begin
			core_irq_valid <= 1'b0;
			core_irq_entry <= `ENTRY_RESET;
		end else begin
			core_irq_valid <= |live;
			if (live[0]) begin
				core_irq_entry <= `ENTRY_EXT0;
			end else if (live[1]) begin
				core_irq_entry <= `ENTRY_TIMER0;
			end else if (live[2]) begin
				core_irq_entry <= `ENTRY_EXT1;
			end else if (live[3]) begin
				core_irq_entry <= `ENTRY_TIMER1;
			end else if (live[4]) begin
				core_irq_entry <= `ENTRY_SERIAL;
			end else begin
				core_irq_entry <= `ENTRY_RESET;
			end
		end
	end
endmodule // core_irq_gate
`default_nettype wire

/* rtl/peripheral_interrupt_vector_unit.v */
// Purpose: combines on-chip peripheral requests into one vectored request
// Assumes: all inputs synchronous to clock; strobes last one cycle
// Notes:   presented vector stays put until firmware retires it
//          a retire clears one flag; next vector follows
//          trigger mode and UART enables are inputs
// What this block does
// - keep timer, external 1, serial entry addresses
// - external 0 at 0003h, reset at 0000h
// - OR all peripheral requests into external 0
// - enable bits per source, reset zero
// - bit 7 gates every interrupt
// - enable register at special address A8h
// - external 0 edge-triggered after reset
// - read-only vector register at FF92h
// - any write retires, next vector loads
// - vector bit 0 always zero
// - no pending source reads 00h
// - group bits 7..4, slot bits 3..1
// - same group served in arrival order
// - higher group number wins
// - hardwired priorities, 84h highest used
// - group 1 out endpoints, group 2 in endpoints
// - group 3 USB bus events
// - group 4 serial bus and endpoint 0
// - UART status, modem, receive, transmit codes
// - group 8 DMA channels 1 and 3
// - UART requests gated by UART enables
`timescale 1ns/100ps
`default_nettype none
`include "irq_vector_defs.vh"
module peripheral_interrupt_vector_unit (
	input  wire        clock,
	input  wire        reset_n,

	// core special-function register port
	// one-cycle strobes, address and data with them
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire [7:0]  sfr_wdata,
	output reg  [7:0]  sfr_rdata,

	// core external data register port
	// write data is ignored; any write retires
	input  wire [15:0] xdata_addr,
	input  wire        xdata_wr,
	input  wire        xdata_rd,
	input  wire [7:0]  xdata_wdata,
	output reg  [7:0]  xdata_rdata,

	// USB endpoint requests, index = endpoint number
	// endpoint 0 goes to group 4, the rest to 1, 2
	input  wire [3:0]  out_ep_irq,
	input  wire [3:0]  in_ep_irq,

	// USB bus events
	// each high cycle sets the event's flag
	input  wire        setup_overwrite_event,
	input  wire        setup_received_event,
	input  wire        resume_request_event,
	input  wire        suspend_request_event,
	input  wire        bus_reset_event,
	input  wire        wakeup_event,

	// serial bus flags
	// levels: held high they pend again
	input  wire        serial_bus_transmit_empty_flag,
	input  wire        serial_bus_receive_full_flag,

	// UART requests and the UART's own enables
	input  wire        uart_status_event,
	input  wire        uart_modem_event,
	input  wire        uart_receive_full_flag,
	input  wire        uart_transmit_empty_flag,
	input  wire        uart_modem_irq_enable,
	input  wire        uart_status_irq_enable,
	input  wire        uart_data_irq_enable,

	// DMA channel requests
	// channel 2 has no code and is not wired
	input  wire        dma1_irq,
	input  wire        dma3_irq,

	// standard core sources and trigger mode
	// gated by the enable register, never vectored
	input  wire        timer0_irq,
	input  wire        ext1_irq,
	input  wire        timer1_irq,
	input  wire        serial_irq,
	input  wire        combined_peripheral_request_level_select,

	// results
	output wire        combined_peripheral_request_n,
	output wire [7:0]  pending_source_vector,
	output wire [7:0]  core_interrupt_enable,
	output wire        core_irq_valid,
	output wire [15:0] core_irq_entry
);
	// flat index = (group - 1) * 8 + slot
	reg  [63:0] src_set;       // flat request vector, eight slots per group
	wire [63:0] src_clr;       // retire strobe for one flat source
	wire [7:0]  grp_any;       // group has something pending
	wire [23:0] grp_win;       // three-bit winner per group
	wire [63:0] grp_pend;      // pending flags of every slot
	reg  [7:0]  vector_q;      // presented vector
	reg  [7:0]  next_vec;      // best candidate right now
	reg         combined_n_q;  // combined request, active low
	wire        retire;        // firmware write to the vector register
	wire [7:0]  ie_value;      // enable register contents
	reg  [3:0]  gnum;          // scan helper: group number
	integer     g;             // scan index

	// flat index of the source behind a presented vector
	// so a retire clears that one flag only
	function [5:0] vec_to_flat;
		input [7:0] vec;
		reg   [3:0] grp_m1;
		begin
			grp_m1      = vec[7:4] - `GROUP_BASE;
			vec_to_flat = {grp_m1[2:0], vec[3:1]};
		end
	endfunction

	// vector register address; the retire strobe and
	// the read port both decode it
	function addr_is_vector;
		input [15:0] addr;
		begin
			addr_is_vector = (addr == `ADDR_VECTOR);
		end
	endfunction

	// place each peripheral request in its group slot
	// plain wiring: no source reaches a reserved code
	// group 7 has an arbiter but nothing wired to it
	always @* begin
		src_set = 64'h0000_0000_0000_0000;
		// groups 1 and 2: endpoints 1 to 3
		src_set[`SRC_OUT_EP1]    = out_ep_irq[1];
		src_set[`SRC_OUT_EP2]    = out_ep_irq[2];
		src_set[`SRC_OUT_EP3]    = out_ep_irq[3];
		src_set[`SRC_IN_EP1]     = in_ep_irq[1];
		src_set[`SRC_IN_EP2]     = in_ep_irq[2];
		src_set[`SRC_IN_EP3]     = in_ep_irq[3];

		// group 3: bus events
		src_set[`SRC_SETUP_OVR]  = setup_overwrite_event;
		src_set[`SRC_SETUP_RX]   = setup_received_event;
		src_set[`SRC_RESUME]     = resume_request_event;
		src_set[`SRC_SUSPEND]    = suspend_request_event;
		src_set[`SRC_BUS_RESET]  = bus_reset_event;
		src_set[`SRC_WAKEUP]     = wakeup_event;

		// group 4: serial bus, then endpoint 0
		src_set[`SRC_SB_TXE]     = serial_bus_transmit_empty_flag;
		src_set[`SRC_SB_RXF]     = serial_bus_receive_full_flag;
		src_set[`SRC_IN_EP0]     = in_ep_irq[0];
		src_set[`SRC_OUT_EP0]    = out_ep_irq[0];

		// UART sources only count while the UART enables them
		src_set[`SRC_UART_STAT]  = uart_status_event & uart_status_irq_enable;
		src_set[`SRC_UART_MODEM] = uart_modem_event & uart_modem_irq_enable;
		src_set[`SRC_UART_RXF]   = uart_receive_full_flag & uart_data_irq_enable;
		src_set[`SRC_UART_TXE]   = uart_transmit_empty_flag & uart_data_irq_enable;

		// group 8: two DMA channels
		src_set[`SRC_DMA1]       = dma1_irq;
		src_set[`SRC_DMA3]       = dma3_irq;
		// reserved and unused slots stay zero, so they never present
	end

	// any write to the vector address retires, whatever the data
	// firmware may write back what it read, or anything
	assign retire = xdata_wr && addr_is_vector(xdata_addr);

	// clear only the source that is presented; nothing if none is
	// a stray write at 00h must not clear a flag that
	// has arrived but has not been shown yet
	assign src_clr = (retire && vector_q != `VEC_NONE) ?
		(64'h0000_0000_0000_0001 << vec_to_flat(vector_q)) :
		64'h0000_0000_0000_0000;

	// one arrival-order arbiter per group, unused group 7 included
	// groups never compete here; the scan does that,
	// so a busy low group cannot hold back a higher one
	genvar gi;
	generate
		for (gi = 0; gi < `SLOT_COUNT; gi = gi + 1) begin : g_group
			source_order_arbiter u_arb (
				.clock       (clock),
				.reset_n     (reset_n),
				.set_req     (src_set[gi*8 +: 8]),
				.clr_req     (src_clr[gi*8 +: 8]),
				.pending_q   (grp_pend[gi*8 +: 8]),
				.any_pending (grp_any[gi]),
				.winner      (grp_win[gi*3 +: 3])
			);
		end
	endgenerate

	// highest group number with anything pending wins
	// each arbiter already picked its oldest slot, so
	// eight candidates remain; no state, one cycle deep
	// group numbers differ, so no tie is possible
	always @* begin
		next_vec = `VEC_NONE;
		gnum     = `GROUP_BASE;
		for (g = 0; g < `SLOT_COUNT; g = g + 1) begin
			gnum = g[3:0] + `GROUP_BASE;
			if (grp_any[g]) begin
				// later groups overwrite earlier ones
				next_vec = {gnum, grp_win[g*3 +: 3], 1'b0};
			end
		end
	end

	// vector register: loads when empty, empties on retire
	// holding it steady keeps the dispatch value firmware just read
	// from changing under it when a higher group arrives meanwhile
	// limitation: a higher group waits one service pass
	// preempting is faster but could retire a vector
	// that firmware never read
	// firmware must allow the 00h cycle after a retire
	always @(posedge clock) begin
		if (!reset_n) begin
			vector_q <= `VEC_NONE;
		end else if (retire) begin
			// next pending vector loads on the following edge
			vector_q <= `VEC_NONE;
		end else if (vector_q == `VEC_NONE) begin
			vector_q <= next_vec;
		end
	end

	// combined request: low while any source is pending
	// taken from the flags, so it falls as the vector
	// loads and stays low across the 00h gap while
	// more wait; a flop keeps it glitch free
	always @(posedge clock) begin
		if (!reset_n) begin
			combined_n_q <= 1'b1;
		end else begin
			combined_n_q <= ~(|grp_any);
		end
	end

	// read data for the core's external data port
	// one cycle of data, then 00h, so the core can OR
	// this port with the read ports of other blocks
	always @(posedge clock) begin
		if (!reset_n) begin
			xdata_rdata <= 8'h00;
		end else if (xdata_rd && addr_is_vector(xdata_addr)) begin
			xdata_rdata <= vector_q;
		end else begin
			// other addresses belong to other blocks; drive zero
			xdata_rdata <= 8'h00;
		end
	end

	// read data for the special-function port
	// other special-function addresses read 00h here
	always @(posedge clock) begin
		if (!reset_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd && sfr_addr == `ADDR_CORE_IE) begin
			sfr_rdata <= ie_value;
		end else begin
			sfr_rdata <= 8'h00;
		end
	end

	// enable register and standard source gating
	// core sources share only the enable register;
	// its bit 0 gates the combined line into the core
	// entry and valid trail the sources by one edge
	core_irq_gate u_gate (
		.clock             (clock),
		.reset_n           (reset_n),
		.sfr_addr          (sfr_addr),
		.sfr_wr            (sfr_wr),
		.sfr_wdata         (sfr_wdata),
		.combined_n        (combined_n_q),
		.combined_peripheral_request_level_select (combined_peripheral_request_level_select),
		.timer0_irq        (timer0_irq),
		.ext1_irq          (ext1_irq),
		.timer1_irq        (timer1_irq),
		.serial_irq        (serial_irq),
		.ie_q              (ie_value),
		.core_irq_valid    (core_irq_valid),
		.core_irq_entry    (core_irq_entry)
	);

	// outputs straight from flops
	// no logic between these flops and the pins
	assign combined_peripheral_request_n = combined_n_q;
	assign pending_source_vector         = vector_q;
	assign core_interrupt_enable         = ie_value;
endmodule // peripheral_interrupt_vector_unit
`default_nettype wire

/* testbench/vector_unit_asserts.sv */
// Purpose: port-level checks of the peripheral interrupt vector unit
// Assumes: bound to the top module, single clock domain
// Notes:   only the ports these properties need are wired in
`timescale 1ns/100ps
`default_nettype none
module vector_unit_checker (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [15:0] xdata_addr,
	input wire logic        xdata_wr,
	input wire logic        xdata_rd,
	input wire logic [7:0]  xdata_rdata,
	input wire logic        dma1_irq,
	input wire logic        combined_peripheral_request_n,
	input wire logic [7:0]  pending_source_vector,
	input wire logic [7:0]  core_interrupt_enable,
	input wire logic        core_irq_valid,
	input wire logic [15:0] core_irq_entry
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire vec_hit = (xdata_addr == 16'hff92); // vector register selected
	wire vec_set = (pending_source_vector != 8'h00); // a vector is presented
	// request step, then the combined line answers
	sequence s_dma_req; dma1_irq; endsequence
	sequence s_line_low; !combined_peripheral_request_n; endsequence
	a_dma_combines: assert property (s_dma_req |-> ##2 s_line_low)
		else $error("dma request did not pull the combined line low");
	a_ie_write: assert property (sfr_wr && sfr_addr == 8'ha8 |=>
		core_interrupt_enable == ($past(sfr_wdata) & 8'h9f))
		else $error("enable register write not taken");
	a_ie_reserved: assert property (core_interrupt_enable[6:5] == 2'b00)
		else $error("reserved enable bits set");
	a_gate_off: assert property (!core_interrupt_enable[7] |=> !core_irq_valid)
		else $error("core request with global gate off");
	a_entry_idle: assert property (!core_irq_valid |-> core_irq_entry == 16'h0000)
		else $error("entry address without a request");
	a_vec_even: assert property (!pending_source_vector[0])
		else $error("vector bit 0 set");
	a_vec_ceiling: assert property (pending_source_vector <= 8'h84)
		else $error("vector above highest assigned code");
	a_idle_zero: assert property (combined_peripheral_request_n |-> !vec_set)
		else $error("vector shown while nothing pending");
	a_line_low: assert property (vec_set |-> !combined_peripheral_request_n)
		else $error("combined line high with vector presented");
	a_retire_clears: assert property (xdata_wr && vec_hit && vec_set |=> !vec_set)
		else $error("retire write did not clear vector");
	a_vec_holds: assert property (vec_set && !(xdata_wr && vec_hit) |=>
		$stable(pending_source_vector))
		else $error("presented vector changed without retire");
	a_read_vector: assert property (xdata_rd && vec_hit |=>
		xdata_rdata == $past(pending_source_vector))
		else $error("vector read returned wrong data");
endmodule // vector_unit_checker
bind peripheral_interrupt_vector_unit vector_unit_checker u_chk (
	.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata), .xdata_addr(xdata_addr), .xdata_wr(xdata_wr),
	.xdata_rd(xdata_rd), .xdata_rdata(xdata_rdata), .dma1_irq(dma1_irq),
	.combined_peripheral_request_n(combined_peripheral_request_n),
	.pending_source_vector(pending_source_vector),
	.core_interrupt_enable(core_interrupt_enable),
	.core_irq_valid(core_irq_valid), .core_irq_entry(core_irq_entry));
`default_nettype wire

/* testbench/dispatch_firmware_model.sv */
// Purpose: firmware behind entry 0003h: read vector, dispatch, retire
// Assumes: drives at the falling edge, design samples at the rising edge
// Notes:   stall slows the answer, hold keeps requests waiting
`timescale 1ns/100ps
`default_nettype none
module dispatch_firmware_model (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        combined_n,
	input  wire logic [7:0]  xdata_rdata,
	input  wire logic        hold,
	input  wire logic        stall,
	output var  logic [15:0] xdata_addr,
	output var  logic        xdata_rd,
	output var  logic        xdata_wr,
	output var  logic [7:0]  xdata_wdata,
	output var  logic        combined_peripheral_request_level_select,
	output var  logic        disp_valid,
	output var  logic [7:0]  disp_vec
);
	logic [2:0] step; // 0 idle, 1 read answer, 2..5 settle gap
	initial begin
		{xdata_addr, xdata_rd, xdata_wr, xdata_wdata} = '0;
		{combined_peripheral_request_level_select, disp_valid, disp_vec, step} = '0;
	end
	// one service pass; the gap lets the next vector load after a retire
	always @(negedge clock) begin
		disp_valid <= 1'b0;
		xdata_rd <= 1'b0;
		xdata_wr <= 1'b0;
		xdata_addr <= ~xdata_addr; // idle address never looks settled
		if (!reset_n) begin
			step <= 3'd0;
			combined_peripheral_request_level_select <= 1'b0;
		end else begin
			if (!hold) combined_peripheral_request_level_select <= 1'b1;
			case (step)
			3'd0: if (!combined_n && !hold && !stall) begin
				xdata_rd <= 1'b1;
				xdata_addr <= 16'hff92;
				step <= 3'd1;
			end
			3'd1: begin
				// a 00h answer is the retire gap: nothing to serve
				if (xdata_rdata != 8'h00) begin
					disp_valid <= 1'b1;
					disp_vec <= xdata_rdata;
					xdata_wr <= 1'b1;
					xdata_addr <= 16'hff92;
					xdata_wdata <= ~xdata_rdata;
				end
				step <= 3'd2;
			end
			default: step <= (step == 3'd5) ? 3'd0 : step + 3'd1;
			endcase
		end
	end
endmodule // dispatch_firmware_model
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench of the peripheral interrupt vector unit
// Assumes: firmware model services the combined line
// Notes:   dispatched vectors are matched against a queue of expectations
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clock = 0;
	logic        reset_n = 0;
	logic [7:0]  sfr_addr = 0, sfr_wdata = 0;
	logic        sfr_wr = 0, sfr_rd = 0, hold = 1, stall = 0;
	logic [21:0] src = 0; // peripheral sources in code-table order
	logic [3:0]  csrc = 0; // timer0, ext1, timer1, serial
	logic [2:0]  uen = 3'h7; // uart modem, status, data enables
	wire  [15:0] xaddr, entry;
	wire  [7:0]  xwdata, xrdata, sfr_rdata, vec, ie, dvec;
	wire         xrd, xwr, cn, lvl, valid, dval;
	logic [31:0] seed = 32'hfa3a_7d75;
	logic [7:0]  q[$]; // expected dispatch order
	int          num_errors = 0, n_checks = 0, r;
	logic [7:0]  codes[22] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30,
		8'h32, 8'h38, 8'h3a, 8'h3c, 8'h3e, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50,
		8'h52, 8'h60, 8'h62, 8'h80, 8'h84};
	logic [15:0] ents[4] = '{16'h000b, 16'h0013, 16'h001b, 16'h0023};
	always #50 clock = ~clock;
	peripheral_interrupt_vector_unit dut (.clock(clock), .reset_n(reset_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .xdata_addr(xaddr), .xdata_wr(xwr), .xdata_rd(xrd),
		.xdata_wdata(xwdata), .xdata_rdata(xrdata),
		.out_ep_irq({src[2:0], src[15]}), .in_ep_irq({src[5:3], src[14]}),
		.setup_overwrite_event(src[6]), .setup_received_event(src[7]),
		.resume_request_event(src[8]), .suspend_request_event(src[9]),
		.bus_reset_event(src[10]), .wakeup_event(src[11]),
		.serial_bus_transmit_empty_flag(src[12]), .serial_bus_receive_full_flag(src[13]),
		.uart_status_event(src[16]), .uart_modem_event(src[17]),
		.uart_receive_full_flag(src[18]), .uart_transmit_empty_flag(src[19]),
		.uart_modem_irq_enable(uen[0]), .uart_status_irq_enable(uen[1]),
		.uart_data_irq_enable(uen[2]), .dma1_irq(src[20]), .dma3_irq(src[21]),
		.timer0_irq(csrc[0]), .ext1_irq(csrc[1]), .timer1_irq(csrc[2]),
		.serial_irq(csrc[3]), .combined_peripheral_request_level_select(lvl),
		.combined_peripheral_request_n(cn), .pending_source_vector(vec),
		.core_interrupt_enable(ie), .core_irq_valid(valid), .core_irq_entry(entry));
	dispatch_firmware_model fw (.clock(clock), .reset_n(reset_n), .combined_n(cn),
		.xdata_rdata(xrdata), .hold(hold), .stall(stall), .xdata_addr(xaddr),
		.xdata_rd(xrd), .xdata_wr(xwr), .xdata_wdata(xwdata),
		.combined_peripheral_request_level_select(lvl), .disp_valid(dval), .disp_vec(dvec));
	// xorshift source of all random stimulus
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		{sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
		@(negedge clock) sfr_wr = 0;
	endtask
	task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
		{sfr_addr, sfr_rd} = {a, 1'b1};
		@(negedge clock) sfr_rd = 0;
		check(sfr_rdata, exp, "sfr read");
	endtask
	// one-cycle request; the note goes in the queue only when it must fire
	task automatic pulse(input int i, input bit expect_it);
		src[i] = 1;
		if (expect_it) q.push_back(codes[i]);
		@(negedge clock) src[i] = 0;
	endtask
	task automatic drain();
		repeat (3) @(negedge clock);
		for (int t = 0; t < 300 && (q.size() != 0 || !cn); t++) @(negedge clock);
		check({15'(q.size()), cn}, 16'h0001, "queue left");
	endtask
	// random firmware slowness
	always @(negedge clock) stall <= rnd() > 32'hb000_0000;
	// monitor: every dispatch takes the oldest note
	always @(posedge clock) if (dval) begin
		if (q.size() == 0) check(dvec, 8'h00, "unexpected vector");
		else check(dvec, q.pop_front(), "vector");
	end
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (4) @(negedge clock);
		reset_n = 1;
		@(negedge clock);
		sfr_read(8'ha8, 8'h00);
		sfr_read(8'h80, 8'h00);
		check({vec, 7'h00, cn}, 16'h0001, "idle vector");
		r = rnd();
		sfr_write(8'ha8, r[7:0]);
		sfr_read(8'ha8, r[7:0] & 8'h9f);
		for (int k = 0; k < 4; k++) begin
			sfr_write(8'ha8, 8'h80 | (8'h02 << k));
			csrc[k] = 1;
			repeat (3) @(negedge clock);
			check(entry, ents[k], "core entry");
			sfr_write(8'ha8, 8'h02 << k);
			repeat (3) @(negedge clock);
			check({15'h0, valid}, 16'h0000, "gated valid");
			csrc[k] = 0;
		end
		sfr_write(8'ha8, 8'h81);
		pulse(0, 1);
		repeat (2) @(negedge clock);
		check({15'h0, valid}, 16'h0001, "edge pulse");
		@(negedge clock);
		check({15'h0, valid}, 16'h0000, "edge end");
		hold = 0;
		drain();
		for (int i = 0; i < 22; i++) begin
			pulse(i, 1);
			drain();
		end
		hold = 1;
		pulse(0, 1);
		repeat (4) @(negedge clock);
		check(vec, 8'h12, "held vector");
		check(entry, 16'h0003, "ext0 entry");
		pulse(21, 1);
		pulse(7, 1);
		pulse(4, 1);
		pulse(3, 1);
		hold = 0;
		drain();
		uen = 3'h0;
		for (int i = 16; i < 20; i++) pulse(i, 0);
		drain();
		uen = 3'h7;
		repeat (12) begin
			pulse(rnd() % 22, 1);
			drain();
		end
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
